// ### core/mspwm_pkg.sv
// package of constants and carrier types for the micro-step pwm duty block
package mspwm_pkg;

   // ***********************************************************
   // field widths and scaling
   // ***********************************************************
   localparam int unsigned DIV_W        = 5;   // period divider field width
   localparam int unsigned PRE_W        = 2;   // prescale exponent width
   localparam int unsigned PPW_W        = 8;   // peak pulse-width width
   localparam int unsigned AMP_W        = 8;   // sine amplitude width (full scale 255)
   localparam int unsigned TICKS_SHIFT  = 3;   // period counts divider times 2^3
   localparam int unsigned CNT_W        = 8;   // period counter width (max 31*8-1)
   localparam int unsigned PRE_CNT_W    = 3;   // prescale counter width (max 2^3-1)
   localparam int unsigned PROD_W       = 16;  // amplitude times peak width product
   localparam int unsigned OSC_MHZ      = 27;  // reference oscillator frequency

   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [CNT_W-1:0]     CNT_RST = 8'h00;  // period counter reset
   localparam logic [PRE_CNT_W-1:0] PRE_RST = 3'h0;   // prescale counter reset

   // ***********************************************************
   // carrier types
   // ***********************************************************
   // drive configuration for one motor
   typedef struct packed {
      logic [DIV_W-1:0] pwm_period_divider;     // period divider
      logic [PRE_W-1:0] pwm_prescale_exponent;  // prescale exponent
      logic [PPW_W-1:0] peak_pulse_width;       // peak pulse width
   } mspwm_cfg_type;

   // signed sine target: sign set means negative coil current
   typedef struct packed {
      logic             negative;   // current flows second to first
      logic [AMP_W-1:0] magnitude;  // 0..255 of full sine peak
   } mspwm_target_type;

endpackage : mspwm_pkg

// ### core/mspwm_bridge.sv
// one h-bridge channel: duty compare and polarity steering
module mspwm_bridge
   import mspwm_pkg::*;
(
   input  wire logic             clk_i,              // system clock
   input  wire logic             rst_i,              // synchronous reset
   input  wire logic [CNT_W-1:0] count_i,            // shared period count
   input  wire logic [CNT_W-1:0] width_i,            // clamped on-width
   input  wire logic             negative_i,         // current direction
   output logic                  bridge_out_first_o, // first bridge output
   output logic                  bridge_out_second_o // second bridge output
);

   logic on_w;        // pulse active this count
   logic first_d;     // next first output
   logic second_d;    // next second output
   logic first_q;     // first output register
   logic second_q;    // second output register

   // ***********************************************************
   // compare and steer
   // ***********************************************************
   // pulse is high while count below width; sign picks the driven leg
   always_comb
   begin
      on_w     = (count_i < width_i);
      first_d  = on_w && !negative_i;
      second_d = on_w && negative_i;
   end

   // output registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         first_q  <= 1'b0;
         second_q <= 1'b0;
      end
      else
      begin
         first_q  <= first_d;
         second_q <= second_d;
      end
   end

   assign bridge_out_first_o  = first_q;
   assign bridge_out_second_o = second_q;

   // never both legs high: no shoot-through
   property p_no_overlap;
      @(posedge clk_i) disable iff (rst_i)
      !(first_q && second_q);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("both bridge legs driven");

endmodule // mspwm_bridge

// ### core/mspwm_top.sv
// micro-step pwm carrier and peak duty generator
module mspwm_top
   import mspwm_pkg::*;
(
   input  wire logic             clk_i,              // system oscillator clock
   input  wire logic             rst_i,              // synchronous reset
   input  wire mspwm_cfg_type    cfg_i,              // divider, prescale, peak width
   input  wire mspwm_target_type target_i,           // sine target sample
   output logic                  bridge_out_first_o, // first bridge output
   output logic                  bridge_out_second_o,// second bridge output
   output logic                  period_start_o,     // one-cycle pulse at carrier wrap
   output logic                  duty_clamped_o      // peak duty saturated
);

   // ***********************************************************
   // carrier timing
   // ***********************************************************
   logic [CNT_W-1:0]     period_w;   // ticks per carrier period
   logic [CNT_W-1:0]     cnt_q;      // period counter
   logic [CNT_W-1:0]     cnt_d;      // next period counter
   logic [PRE_CNT_W-1:0] pre_q;      // prescale counter
   logic [PRE_CNT_W-1:0] pre_d;      // next prescale counter
   logic [PRE_CNT_W-1:0] pre_max_w;  // prescale terminal count
   logic                 tick_w;     // prescaled count enable
   logic                 wrap_w;     // last tick of a period
   logic                 start_q;    // period start pulse register
   logic                 start_d;    // next period start pulse

   // period = divider * 8 ticks; a tick is 2^prescale oscillator cycles
   always_comb
   begin
      period_w  = {cfg_i.pwm_period_divider, 3'h0};
      pre_max_w = PRE_CNT_W'((1 << cfg_i.pwm_prescale_exponent) - 1);
      tick_w    = (pre_q >= pre_max_w);
      wrap_w    = tick_w && (cnt_q >= period_w - 8'h01);
      pre_d     = tick_w ? PRE_RST : pre_q + 3'h1;
      if (cfg_i.pwm_period_divider == 5'h00)
         cnt_d = CNT_RST;                          // divider zero clears counter
      else if (wrap_w)
         cnt_d = CNT_RST;                          // restart period
      else if (tick_w)
         cnt_d = cnt_q + 8'h01;                    // advance
      else
         cnt_d = cnt_q;
      start_d = wrap_w && (cfg_i.pwm_period_divider != 5'h00);
   end

   // carrier counters, free-running from the oscillator
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_q   <= CNT_RST;
         pre_q   <= PRE_RST;
         start_q <= 1'b0;
      end
      else
      begin
         cnt_q   <= cnt_d;
         pre_q   <= pre_d;
         start_q <= start_d;
      end
   end

   // ***********************************************************
   // duty computation
   // ***********************************************************
   logic [PROD_W-1:0] prod_w;    // amplitude times peak width
   logic [PROD_W-1:0] scaled_w;  // on-ticks before clamp
   logic [CNT_W-1:0]  width_d;   // clamped on-width
   logic [CNT_W-1:0]  width_q;   // width latched per period
   logic              neg_d;     // next direction
   logic              neg_q;     // direction latched per period
   logic              clamp_d;   // next saturation flag
   logic              clamp_q;   // saturation flag register

   // on-ticks = peak_width * amp/255, so duty = width / (divider*8)
   always_comb
   begin
      prod_w   = target_i.magnitude * cfg_i.peak_pulse_width;
      scaled_w = prod_w / 16'h00FF;
      width_d  = width_q;
      neg_d    = neg_q;
      clamp_d  = clamp_q;
      if (wrap_w || cfg_i.pwm_period_divider == 5'h00)
      begin
         neg_d   = target_i.negative;
         clamp_d = ({8'h00, cfg_i.peak_pulse_width} > {8'h00, period_w});
         if (scaled_w > {8'h00, period_w})
            width_d = period_w;                    // saturate at full duty
         else
            width_d = scaled_w[CNT_W-1:0];
      end
   end

   // width and direction change only at period boundaries, or every cycle while the divider is zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         width_q <= CNT_RST;
         neg_q   <= 1'b0;
         clamp_q <= 1'b0;
      end
      else
      begin
         width_q <= width_d;
         neg_q   <= neg_d;
         clamp_q <= clamp_d;
      end
   end

   // ***********************************************************
   // bridge output stage
   // ***********************************************************
   mspwm_bridge u_bridge
   (
      .clk_i               (clk_i),
      .rst_i               (rst_i),
      .count_i             (cnt_q),
      .width_i             (width_q),
      .negative_i          (neg_q),
      .bridge_out_first_o  (bridge_out_first_o),
      .bridge_out_second_o (bridge_out_second_o)
   );

   assign period_start_o = start_q;
   assign duty_clamped_o = clamp_q;

   // ***********************************************************
   // checks
   // ***********************************************************
   // counter inside the period stays inside it while the setting holds;
   // a stale count after a shorter setting is left to the wrap logic
   property p_cnt_bound;
      @(posedge clk_i) disable iff (rst_i)
      (cfg_i.pwm_period_divider != 5'h00 && cnt_q < period_w)
         |=> ((cnt_q < period_w) || !$stable(cfg_i));
   endproperty
   a_cnt_bound: assert property (p_cnt_bound) else $error("period counter overran");

   // width latched at a wrap never exceeds the period it was latched for
   property p_width_sat;
      @(posedge clk_i) disable iff (rst_i)
      wrap_w |=> (width_q <= $past(period_w));
   endproperty
   a_width_sat: assert property (p_width_sat) else $error("width above full duty");

   // wrap restarts the count next cycle
   property p_wrap_restart;
      @(posedge clk_i) disable iff (rst_i)
      wrap_w |=> (cnt_q == CNT_RST);
   endproperty
   a_wrap_restart: assert property (p_wrap_restart) else $error("no restart after wrap");

   // full width with a positive target keeps the first leg high through the period
   property p_full_duty;
      @(posedge clk_i) disable iff (rst_i)
      (width_q == period_w && width_q != 8'h00 && !neg_q && $stable(cfg_i))
         |=> (bridge_out_first_o || $past(wrap_w));
   endproperty
   a_full_duty: assert property (p_full_duty) else $error("full duty gap");

   // start pulse lasts one cycle
   property p_start_pulse;
      @(posedge clk_i) disable iff (rst_i)
      period_start_o |=> !period_start_o || (period_w == 8'h08 && pre_max_w == 3'h0);
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");

   // positive target never drives the second leg
   property p_dir;
      @(posedge clk_i) disable iff (rst_i)
      (!neg_q) |=> !bridge_out_second_o;
   endproperty
   a_dir: assert property (p_dir) else $error("wrong bridge leg");

   // every wrap of a running carrier raises the start pulse next cycle
   property p_start_follows_wrap;
      @(posedge clk_i) disable iff (rst_i)
      (wrap_w && cfg_i.pwm_period_divider != 5'h00) |=> period_start_o;
   endproperty
   a_start_follows_wrap: assert property (p_start_follows_wrap) else $error("missing start pulse");

   // prescale counter restarts after every tick
   property p_prescale_restart;
      @(posedge clk_i) disable iff (rst_i)
      tick_w |=> (pre_q == PRE_RST);
   endproperty
   a_prescale_restart: assert property (p_prescale_restart) else $error("prescale did not restart");

   // a tick inside the period advances the count by one
   property p_advance;
      @(posedge clk_i) disable iff (rst_i)
      (tick_w && !wrap_w && cfg_i.pwm_period_divider != 5'h00)
         |=> (cnt_q == $past(cnt_q) + 8'h01);
   endproperty
   a_advance: assert property (p_advance) else $error("counter did not advance");

   // width and direction hold between wraps
   property p_width_hold;
      @(posedge clk_i) disable iff (rst_i)
      (!wrap_w && cfg_i.pwm_period_divider != 5'h00) |=> ($stable(width_q) && $stable(neg_q));
   endproperty
   a_width_hold: assert property (p_width_hold) else $error("width changed mid period");

   // a zero divider stops the carrier
   property p_stopped;
      @(posedge clk_i) disable iff (rst_i)
      (cfg_i.pwm_period_divider == 5'h00) |=> (cnt_q == CNT_RST && !period_start_o);
   endproperty
   a_stopped: assert property (p_stopped) else $error("stopped carrier ran");

   // reset leaves every output low on the next cycle
   property p_reset_quiet;
      @(posedge clk_i)
      rst_i |=> (!bridge_out_first_o && !bridge_out_second_o && !period_start_o && !duty_clamped_o);
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("output high after reset");

endmodule // mspwm_top

// ### verification/mspwm_coil_model.sv
// coil-side model that measures carrier period and drive time per direction
module mspwm_coil_model
   import mspwm_pkg::*;
(
   input  wire logic        clk_i,        // system clock
   input  wire logic        rst_i,        // synchronous reset
   input  wire logic        first_i,      // first bridge output
   input  wire logic        second_i,     // second bridge output
   input  wire logic        start_i,      // carrier wrap pulse
   output logic [15:0]      period_len_o, // clocks in last whole period
   output logic [15:0]      pos_on_o,     // clocks of positive drive
   output logic [15:0]      neg_on_o,     // clocks of negative drive
   output logic             shorted_o     // both legs driven at once
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] len_q;  // running period length
   logic [15:0] pos_q;  // running positive drive time
   logic [15:0] neg_q;  // running negative drive time
   // ****************
   // window counters
   // ****************
   // a window runs from one wrap pulse up to the next, so phase does not matter
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         len_q     <= 16'h0000;
         pos_q     <= 16'h0000;
         neg_q     <= 16'h0000;
         shorted_o <= 1'b0;
      end
      else if (start_i)
      begin
         period_len_o <= len_q;
         pos_on_o     <= pos_q;
         neg_on_o     <= neg_q;
         len_q        <= 16'h0001;
         pos_q        <= {15'h0000, first_i};  // first into second is positive
         neg_q        <= {15'h0000, second_i};
      end
      else
      begin
         len_q <= len_q + 16'h0001;
         pos_q <= pos_q + {15'h0000, first_i};
         neg_q <= neg_q + {15'h0000, second_i};
      end
      // both legs on would short the supply through the coil
      if (!rst_i && first_i && second_i)
      begin
         shorted_o <= 1'b1;
      end
   end
endmodule // mspwm_coil_model

// ### verification/test_mspwm_top.sv
// self-checking bench for the micro-step pwm duty generator
module test_mspwm_top
   import mspwm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic             clk_i;  // system clock
   logic             rst_i;  // synchronous reset
   mspwm_cfg_type    cfg_i;  // divider, prescale, peak width
   mspwm_target_type target_i; // sine target
   logic             first_o, second_o, start_o, clamp_o; // design outputs
   logic [15:0]      len_m, pos_m, neg_m; // model measurements
   logic             short_m; // model short flag
   int               miscompares = 0;
   int               n_tests = 0;
   mspwm_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg_i), .target_i(target_i),
      .bridge_out_first_o(first_o), .bridge_out_second_o(second_o),
      .period_start_o(start_o), .duty_clamped_o(clamp_o));
   mspwm_coil_model u_coil (.clk_i(clk_i), .rst_i(rst_i), .first_i(first_o), .second_i(second_o),
      .start_i(start_o), .period_len_o(len_m), .pos_on_o(pos_m), .neg_on_o(neg_m), .shorted_o(short_m));
   // ****************
   // clock
   // ****************
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // compares one value and counts it
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // prints the verdict and ends the run
   task automatic summarize();
      if (miscompares == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // applies a setting, lets three wraps pass, then judges the last period
   task automatic run(input int dv, input int pr, input int pk, input int mg, input logic ng);
      int w;
      int n;
      int k;
      @(negedge clk_i);
      cfg_i    = {5'(dv), 2'(pr), 8'(pk)};
      target_i = {ng, 8'(mg)};
      w = mg * pk / 255;
      if (w > dv * 8)
         w = dv * 8; // saturate at full duty
      n = 0;
      for (k = 0; k < 8000 && n < 3; k++)
      begin
         @(negedge clk_i);
         if (start_o === 1'b1)
            n++;
      end
      if (n < 3)
      begin
         miscompares++;
         summarize();
      end
      else
      begin
         @(negedge clk_i);
         check("period", len_m, 16'((dv * 8) << pr));
         check("positive drive", pos_m, ng ? 16'h0000 : 16'(w << pr));
         check("negative drive", neg_m, ng ? 16'(w << pr) : 16'h0000);
         check("clamp flag", {15'h0000, clamp_o}, {15'h0000, pk > dv * 8});
      end
   endtask
   // every prescale at both ends of the divider field
   task automatic sc_carrier();
      for (int p = 0; p < 4; p++)
      begin
         run(1, p, 8, 255, 1'b0);
         run(31, p, 200, 255, 1'b0);
      end
   endtask
   // larger divider chosen for finer amplitude steps
   task automatic sc_peak();
      run(30, 1, 200, 255, 1'b0);
      run(30, 1, 200, 51, 1'b0);
   endtask
   // peak above full scale flattens the sine top
   task automatic sc_saturate();
      run(10, 0, 96, 255, 1'b0);
      run(10, 0, 96, 85, 1'b0);
      run(5, 2, 255, 255, 1'b0);
   endtask
   // negative current uses the second leg only
   task automatic sc_reverse();
      run(10, 0, 96, 85, 1'b1);
      run(30, 1, 200, 255, 1'b1);
   endtask
   // stopped divider stays silent, reset in mid-run clears outputs
   task automatic sc_stop_reset();
      int act;
      @(negedge clk_i);
      rst_i = 1'b1;
      cfg_i = {5'h00, 2'h0, 8'hFF};
      @(negedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      act = 0;
      repeat (200)
      begin
         @(negedge clk_i);
         act += int'(start_o | first_o | second_o);
      end
      check("stopped activity", 16'(act), 16'h0000);
      run(2, 0, 12, 255, 1'b0);
      @(negedge clk_i);
      rst_i = 1'b1;
      @(negedge clk_i);
      check("outputs in reset", {12'h000, first_o, second_o, start_o, clamp_o}, 16'h0000);
      rst_i = 1'b0;
   endtask
   // ****************
   // main sequence
   // ****************
   initial
   begin
      rst_i    = 1'b1;
      cfg_i    = '0;
      target_i = '0;
      repeat (3) @(negedge clk_i);
      rst_i = 1'b0;
      sc_carrier();
      sc_peak();
      sc_saturate();
      sc_reverse();
      sc_stop_reset();
      check("leg overlap", {15'h0000, short_m}, 16'h0000);
      summarize();
   end
endmodule // test_mspwm_top
